// *** csla_consts.svh ***
// Offsets, field positions, reset values and timing figures of the status lamp encoder
`ifndef CSLA_CONSTS_SVH
`define CSLA_CONSTS_SVH

// ==========================================================
// Register byte offsets
`define CSLA_REG_STATUS     8'h00
`define CSLA_REG_IRQ_STAT   8'h04
`define CSLA_REG_IRQ_CLR    8'h08
`define CSLA_REG_IRQ_EN     8'h0c
`define CSLA_REG_BLINK      8'h10

// ==========================================================
// Status register fields
`define CSLA_ST_FAULT_LSB   0
`define CSLA_ST_HPLL_POS    8
`define CSLA_ST_LPLL_POS    9
`define CSLA_ST_MAJOR_POS   16
`define CSLA_ST_MINOR_POS   17
`define CSLA_ST_PRES_POS    18
`define CSLA_ST_BLINK_POS   19

// Interrupt status / clear / enable fields
`define CSLA_IRQ_MAJOR      0
`define CSLA_IRQ_MINOR      1
`define CSLA_IRQ_PRES       2
`define CSLA_IRQ_MZFAIL     3
`define CSLA_IRQ_W          4

// ==========================================================
// Reset values
`define CSLA_BLINK_RST      16'h00fa
`define CSLA_IRQ_EN_RST     4'h0

// ==========================================================
// Timing: blink step of one millisecond at a 8 ns clock
`define CSLA_CLK_NS         8
`define CSLA_TICK_NS        1000000
`define CSLA_TICK_CYCLES    (`CSLA_TICK_NS / `CSLA_CLK_NS)

`endif

// *** csla_pkg.sv ***
// Types shared by the status lamp encoder
`default_nettype none

package csla_pkg;

   // ==========================================================
   // Card lifecycle, one-hot
   typedef enum logic [5:0] {
      CSLA_LC_PLUGGED              = 6'h01,
      CSLA_LC_INIT                 = 6'h02,
      CSLA_LC_DOWNLOAD             = 6'h04,
      CSLA_LC_OUT_OF_SERVICE_STATE = 6'h08,
      CSLA_LC_ACTIVE               = 6'h10,
      CSLA_LC_FAILED               = 6'h20
   } csla_lc_t;

   // Mezzanine health, one-hot
   typedef enum logic [3:0] {
      CSLA_MZ_ACTIVE = 4'h1,
      CSLA_MZ_MAJOR  = 4'h2,
      CSLA_MZ_MINOR  = 4'h4,
      CSLA_MZ_IDLE   = 4'h8
   } csla_mz_t;

   // ==========================================================
   // Fault conditions from the card's control logic
   typedef struct packed {
      logic msg_fail;
      logic tx_pending;
      logic rx_pending;
      logic combus_fail;
      logic tx_overrun;
      logic rx_overrun;
      logic comm_fail;
      logic sync_loss;
   } csla_faults_t;

   typedef struct packed {
      logic green;
      logic yellow;
      logic red;
   } csla_lamp_t;

   // ==========================================================
   // Wishbone classic request and answer
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } csla_wb_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } csla_wb_rsp_t;

   // ==========================================================
   // Whole state of the encoder
   typedef struct packed {
      logic         pres_m;
      logic         pres_s;
      logic         hpll_m;
      logic         hpll_s;
      logic         lpll_m;
      logic         lpll_s;
      logic [16:0]  ms_cnt;
      logic [15:0]  half_cnt;
      logic         blink;
      csla_lamp_t   card;
      csla_lamp_t   mezz;
      logic         pres_led;
      logic         major;
      logic         minor;
      logic         mzfail;
      logic [3:0]   irq_stat;
      logic [3:0]   irq_en;
      logic         irq;
      logic [15:0]  blink_half;
      csla_wb_rsp_t rsp;
   } csla_state_t;

endpackage

`default_nettype wire

// *** csla_top.sv ***
// Front-panel lamp encoder and alarm classifier with a Wishbone register slave
//
// Register access over Wishbone and the register addresses are this design's own decisions.
`default_nettype none
`include "csla_consts.svh"

module csla_top #(
   parameter int TICK_CYCLES = `CSLA_TICK_CYCLES
) (
   input  wire logic                  ref_clk,
   input  wire logic                  srst,
   input  wire csla_pkg::csla_wb_req_t wb_req,
   output var  csla_pkg::csla_wb_rsp_t wb_rsp,
   input  wire csla_pkg::csla_lc_t    card_state,
   input  wire csla_pkg::csla_mz_t    mezz_state,
   input  wire logic                  mezz_installed,
   input  wire logic                  high_rate_pll_lock,
   input  wire logic                  low_rate_pll_lock,
   input  wire csla_pkg::csla_faults_t faults,
   output var  csla_pkg::csla_lamp_t  card_lamp,
   output var  csla_pkg::csla_lamp_t  mezz_lamp,
   output var  logic                  mezz_presence_led,
   output var  logic                  major_alarm,
   output var  logic                  minor_alarm,
   output var  logic                  irq
);

   // ==========================================================
   // Lamp pattern helpers
   function automatic csla_pkg::csla_lamp_t lamp(input logic g, input logic y, input logic r);
      csla_pkg::csla_lamp_t l;
      l.green  = g;
      l.yellow = y;
      l.red    = r;
      return l;
   endfunction

   function automatic csla_pkg::csla_lamp_t card_pattern(input csla_pkg::csla_lc_t lc,
                                                         input logic maj,
                                                         input logic mnr,
                                                         input logic blk);
      csla_pkg::csla_lamp_t l;
      l = lamp(1'b1, 1'b0, 1'b1);
      if (lc == csla_pkg::CSLA_LC_FAILED) begin
         l = lamp(1'b1, 1'b0, 1'b1);
      end else if (maj) begin
         l = lamp(1'b0, 1'b0, 1'b1);
      end else if (mnr) begin
         l = lamp(1'b0, 1'b1, 1'b0);
      end else begin
         case (lc)
            csla_pkg::CSLA_LC_PLUGGED:              l = lamp(1'b1, 1'b1, 1'b1);
            csla_pkg::CSLA_LC_INIT:                 l = lamp(1'b1, blk, 1'b0);
            csla_pkg::CSLA_LC_DOWNLOAD:             l = lamp(blk, 1'b0, 1'b0);
            csla_pkg::CSLA_LC_OUT_OF_SERVICE_STATE: l = lamp(1'b1, 1'b0, 1'b0);
            csla_pkg::CSLA_LC_ACTIVE:               l = lamp(1'b0, 1'b0, 1'b0);
            // Unknown code is shown as a card failure
            default:                                l = lamp(1'b1, 1'b0, 1'b1);
         endcase
      end
      return l;
   endfunction

   function automatic csla_pkg::csla_lamp_t mezz_pattern(input logic pres,
                                                         input csla_pkg::csla_mz_t mz);
      csla_pkg::csla_lamp_t l;
      l = lamp(1'b0, 1'b0, 1'b0);
      if (pres) begin
         case (mz)
            csla_pkg::CSLA_MZ_MAJOR:  l = lamp(1'b0, 1'b0, 1'b1);
            csla_pkg::CSLA_MZ_MINOR:  l = lamp(1'b0, 1'b1, 1'b0);
            csla_pkg::CSLA_MZ_IDLE:   l = lamp(1'b1, 1'b0, 1'b0);
            csla_pkg::CSLA_MZ_ACTIVE: l = lamp(1'b0, 1'b0, 1'b0);
            default:                  l = lamp(1'b0, 1'b0, 1'b1);
         endcase
      end
      return l;
   endfunction

   // ==========================================================
   // Alarm classification
   csla_pkg::csla_state_t q;
   csla_pkg::csla_state_t d;
   logic                  major_w;
   logic                  minor_w;
   logic                  tick_w;
   logic                  half_end_w;
   logic [15:0]           half_lim;

   // major set: sync loss, comms failure, rx/tx overrun and comm bus failure
   assign major_w = faults.sync_loss | faults.comm_fail | faults.rx_overrun
                  | faults.tx_overrun | faults.combus_fail;
   assign minor_w = faults.msg_fail | ~q.hpll_s | ~q.lpll_s
                  | (faults.rx_pending & ~faults.rx_overrun)
                  | (faults.tx_pending & ~faults.tx_overrun);

   // prescaler, zero half period runs as one
   assign half_lim   = (q.blink_half == 16'h0000) ? 16'h0001 : q.blink_half;
   assign tick_w     = (q.ms_cnt == 17'(TICK_CYCLES - 1));
   assign half_end_w = (q.half_cnt >= (half_lim - 16'h0001));

   // ==========================================================
   // Next state
   always_comb begin
      logic                 hit;
      logic [3:0]           clr;
      logic [3:0]           ev;
      csla_pkg::csla_lamp_t mz;
      d   = q;
      hit = wb_req.cyc & wb_req.stb & ~q.rsp.ack;
      clr = 4'h0;
      ev  = 4'h0;
      mz  = mezz_pattern(q.pres_s, mezz_state);

      // Pins from outside the clock domain
      d.pres_m = mezz_installed;
      d.pres_s = q.pres_m;
      d.hpll_m = high_rate_pll_lock;
      d.hpll_s = q.hpll_m;
      d.lpll_m = low_rate_pll_lock;
      d.lpll_s = q.lpll_m;

      d.ms_cnt = tick_w ? 17'h00000 : q.ms_cnt + 17'h00001;
      if (tick_w) begin
         if (half_end_w) begin
            d.half_cnt = 16'h0000;
            d.blink    = ~q.blink;
         end else begin
            d.half_cnt = q.half_cnt + 16'h0001;
         end
      end

      d.pres_led = q.pres_s;
      d.mezz     = mz;
      d.card     = card_pattern(card_state, major_w, minor_w, q.blink);
      d.major    = major_w;
      d.minor    = minor_w;
      d.mzfail   = mz.red | mz.yellow;

      // Register slave, one wait cycle per access
      d.rsp.ack = hit;
      if (hit) begin
         d.rsp.dat = 32'h00000000;
         case ({wb_req.adr[7:2], 2'b00})
            `CSLA_REG_STATUS: begin
               d.rsp.dat[`CSLA_ST_FAULT_LSB +: 8] = faults;
               d.rsp.dat[`CSLA_ST_HPLL_POS]       = q.hpll_s;
               d.rsp.dat[`CSLA_ST_LPLL_POS]       = q.lpll_s;
               d.rsp.dat[`CSLA_ST_MAJOR_POS]      = q.major;
               d.rsp.dat[`CSLA_ST_MINOR_POS]      = q.minor;
               d.rsp.dat[`CSLA_ST_PRES_POS]       = q.pres_led;
               d.rsp.dat[`CSLA_ST_BLINK_POS]      = q.blink;
            end
            `CSLA_REG_IRQ_STAT: d.rsp.dat[3:0] = q.irq_stat;
            `CSLA_REG_IRQ_EN:   d.rsp.dat[3:0] = q.irq_en;
            `CSLA_REG_BLINK:    d.rsp.dat[15:0] = q.blink_half;
            default:            d.rsp.dat = 32'h00000000;
         endcase
         if (wb_req.we) begin
            case ({wb_req.adr[7:2], 2'b00})
               `CSLA_REG_IRQ_CLR: begin
                  if (wb_req.sel[0]) begin
                     clr = wb_req.dat[3:0];
                  end
               end
               `CSLA_REG_IRQ_EN: begin
                  if (wb_req.sel[0]) begin
                     d.irq_en = wb_req.dat[3:0];
                  end
               end
               `CSLA_REG_BLINK: begin
                  if (wb_req.sel[0]) begin
                     d.blink_half[7:0] = wb_req.dat[7:0];
                  end
                  if (wb_req.sel[1]) begin
                     d.blink_half[15:8] = wb_req.dat[15:8];
                  end
               end
               default: d.irq_en = q.irq_en;
            endcase
         end
      end

      // Sticky events; a new event beats a clear in the same cycle
      ev[`CSLA_IRQ_MAJOR] = major_w & ~q.major;
      ev[`CSLA_IRQ_MINOR] = minor_w & ~q.minor;
      ev[`CSLA_IRQ_PRES]  = q.pres_s ^ q.pres_led;
      ev[`CSLA_IRQ_MZFAIL] = d.mzfail & ~q.mzfail;
      d.irq_stat = (q.irq_stat & ~clr) | ev;
      d.irq      = |(d.irq_stat & d.irq_en);
   end

   // ==========================================================
   // State register
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         q            <= '0;
         q.irq_en     <= `CSLA_IRQ_EN_RST;
         q.blink_half <= `CSLA_BLINK_RST;
      end else begin
         q <= d;
      end
   end

   assign wb_rsp            = q.rsp;
   assign card_lamp         = q.card;
   assign mezz_lamp         = q.mezz;
   assign mezz_presence_led = q.pres_led;
   assign major_alarm       = q.major;
   assign minor_alarm       = q.minor;
   assign irq               = q.irq;

   // ==========================================================
   // Checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   chk_presence_lamp: assert property (
      !$past(srst) |-> mezz_presence_led == $past(q.pres_s))
      else $error("presence lamp does not follow fitted mezzanine");

   chk_mezz_major_red: assert property (
      !$past(srst) && $past(q.pres_s) && $past(mezz_state) == csla_pkg::CSLA_MZ_MAJOR
      |-> mezz_lamp == 3'b001)
      else $error("mezzanine major failure not red only");

   chk_mezz_minor_yel: assert property (
      !$past(srst) && $past(q.pres_s) && $past(mezz_state) == csla_pkg::CSLA_MZ_MINOR
      |-> mezz_lamp == 3'b010)
      else $error("mezzanine minor failure not yellow only");

   chk_mezz_idle_green: assert property (
      !$past(srst) && $past(q.pres_s) && $past(mezz_state) == csla_pkg::CSLA_MZ_IDLE
      |-> mezz_lamp == 3'b100)
      else $error("mezzanine idle not green only");

   chk_plugged_all_on: assert property (
      !$past(srst) && $past(card_state) == csla_pkg::CSLA_LC_PLUGGED
      && !$past(major_w) && !$past(minor_w) |-> card_lamp == 3'b111)
      else $error("plugged card not showing all lamps");

   chk_active_dark: assert property (
      !$past(srst) && $past(card_state) == csla_pkg::CSLA_LC_ACTIVE
      && !$past(major_w) && !$past(minor_w) |-> card_lamp == 3'b000)
      else $error("active card lamps not dark");

   chk_sync_loss_red: assert property (
      !$past(srst) && $past(faults.sync_loss)
      && $past(card_state) == csla_pkg::CSLA_LC_ACTIVE |-> card_lamp == 3'b001 && major_alarm)
      else $error("timing loss not shown as major");

   chk_rx_overrun_red: assert property (
      !$past(srst) && $past(faults.rx_overrun)
      && $past(card_state) == csla_pkg::CSLA_LC_ACTIVE |-> card_lamp == 3'b001)
      else $error("receive overrun not shown as major");

   chk_rx_pending_yel: assert property (
      !$past(srst) && $past(faults.rx_pending) && !$past(faults.rx_overrun) && !$past(major_w)
      && $past(card_state) == csla_pkg::CSLA_LC_ACTIVE |-> card_lamp == 3'b010 && minor_alarm)
      else $error("receive overrun pending not shown as minor");

   chk_blink_step: assert property (
      !$past(srst) && $changed(q.blink) |-> $past(tick_w) && $past(half_end_w))
      else $error("blink toggled off the prescaler step");

   chk_failure_first: assert property (
      !$past(srst) && $past(card_state) == csla_pkg::CSLA_LC_FAILED |-> card_lamp == 3'b101)
      else $error("failure state did not win priority");

   chk_combus_major: assert property (
      !$past(srst) && $past(faults.combus_fail) |-> major_alarm)
      else $error("comm bus failure not a major alarm");

   chk_comm_major: assert property (
      !$past(srst) && $past(faults.comm_fail) |-> major_alarm)
      else $error("communications failure not a major alarm");

   chk_no_fault_quiet: assert property (
      !$past(srst) && $past(faults) == 8'h00 && $past(q.hpll_s) && $past(q.lpll_s)
      |-> !major_alarm && !minor_alarm)
      else $error("alarm raised with no fault present");

   chk_tx_overrun_red: assert property (
      !$past(srst) && $past(faults.tx_overrun)
      && $past(card_state) == csla_pkg::CSLA_LC_ACTIVE |-> card_lamp == 3'b001 && major_alarm)
      else $error("transmit overrun not shown as major");

   chk_tx_pending_yel: assert property (
      !$past(srst) && $past(faults.tx_pending) && !$past(faults.tx_overrun) && !$past(major_w)
      && $past(card_state) == csla_pkg::CSLA_LC_ACTIVE |-> card_lamp == 3'b010 && minor_alarm)
      else $error("transmit overrun pending not shown as minor");

   chk_hpll_minor: assert property (
      !$past(srst) && !$past(q.hpll_s) |-> minor_alarm)
      else $error("high-rate clock unlocked without minor alarm");

   chk_lpll_minor: assert property (
      !$past(srst) && !$past(q.lpll_s) |-> minor_alarm)
      else $error("low-rate clock unlocked without minor alarm");

   chk_msg_fail_minor: assert property (
      !$past(srst) && $past(faults.msg_fail) |-> minor_alarm)
      else $error("messaging failure not a minor alarm");

   chk_major_red_only: assert property (
      !$past(srst) && $past(major_w) && $past(card_state) != csla_pkg::CSLA_LC_FAILED
      |-> card_lamp == 3'b001)
      else $error("major alarm not shown as red only");

   chk_minor_yel_only: assert property (
      !$past(srst) && $past(minor_w) && !$past(major_w)
      && $past(card_state) != csla_pkg::CSLA_LC_FAILED |-> card_lamp == 3'b010)
      else $error("minor alarm alone not shown as yellow only");

   chk_init_pattern: assert property (
      !$past(srst) && $past(card_state) == csla_pkg::CSLA_LC_INIT && !$past(major_w)
      && !$past(minor_w) |-> card_lamp == {1'b1, $past(q.blink), 1'b0})
      else $error("initialising card pattern wrong");

   chk_download_blink: assert property (
      !$past(srst) && $past(card_state) == csla_pkg::CSLA_LC_DOWNLOAD && !$past(major_w)
      && !$past(minor_w) |-> card_lamp == {$past(q.blink), 1'b0, 1'b0})
      else $error("download card pattern wrong");

   chk_idle_green_only: assert property (
      !$past(srst) && $past(card_state) == csla_pkg::CSLA_LC_OUT_OF_SERVICE_STATE
      && !$past(major_w) && !$past(minor_w) |-> card_lamp == 3'b100)
      else $error("out of service card not green only");

   chk_mezz_absent_dark: assert property (
      !$past(srst) && !$past(q.pres_s) |-> mezz_lamp == 3'b000)
      else $error("mezzanine lamps lit with no mezzanine");

   chk_major_irq_set: assert property (
      !$past(srst) && $past(major_w) && !$past(q.major) && $past(d.irq_en[`CSLA_IRQ_MAJOR])
      |-> irq && q.irq_stat[`CSLA_IRQ_MAJOR])
      else $error("new major alarm did not raise the interrupt");

   chk_ack_one_cycle: assert property (
      wb_rsp.ack |=> !wb_rsp.ack)
      else $error("bus acknowledge stood longer than one cycle");

endmodule

`default_nettype wire

// *** test_card_status_led_alarm_encoder.sv ***
// Self-checking bench for the card status lamp encoder
`default_nettype none
`include "csla_consts.svh"

module test_card_status_led_alarm_encoder;
   timeunit 1ns;
   timeprecision 1ps;

   // Short blink tick keeps the run small
   localparam int TICKS = 4;

   logic                   ref_clk            = 1'b0;
   logic                   srst               = 1'b1;
   csla_pkg::csla_wb_req_t wb_req             = '0;
   csla_pkg::csla_wb_rsp_t wb_rsp;
   csla_pkg::csla_lc_t     card_state         = csla_pkg::CSLA_LC_ACTIVE;
   csla_pkg::csla_mz_t     mezz_state         = csla_pkg::CSLA_MZ_ACTIVE;
   logic                   mezz_installed     = 1'b0;
   logic                   high_rate_pll_lock = 1'b1;
   logic                   low_rate_pll_lock  = 1'b1;
   csla_pkg::csla_faults_t faults             = '0;
   csla_pkg::csla_lamp_t   card_lamp;
   csla_pkg::csla_lamp_t   mezz_lamp;
   logic                   mezz_presence_led;
   logic                   major_alarm;
   logic                   minor_alarm;
   logic                   irq;
   int                     n_errors           = 0;
   int                     num_checks         = 0;

   csla_top #(.TICK_CYCLES(TICKS)) uut (
      .ref_clk            (ref_clk),
      .srst               (srst),
      .wb_req             (wb_req),
      .wb_rsp             (wb_rsp),
      .card_state         (card_state),
      .mezz_state         (mezz_state),
      .mezz_installed     (mezz_installed),
      .high_rate_pll_lock (high_rate_pll_lock),
      .low_rate_pll_lock  (low_rate_pll_lock),
      .faults             (faults),
      .card_lamp          (card_lamp),
      .mezz_lamp          (mezz_lamp),
      .mezz_presence_led  (mezz_presence_led),
      .major_alarm        (major_alarm),
      .minor_alarm        (minor_alarm),
      .irq                (irq)
   );

   always #4 ref_clk = ~ref_clk;

   // ==========================================================
   // Compare and closing
   task automatic chk_bit(input logic got, input logic want);
      num_checks++;
      if (got !== want) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, want);
      end
   endtask

   task automatic chk_lamp(input csla_pkg::csla_lamp_t got, input csla_pkg::csla_lamp_t want);
      num_checks++;
      if (got !== want) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, want);
      end
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] want);
      num_checks++;
      if (got !== want) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, want);
      end
   endtask

   task automatic wrap_up();
      if (n_errors == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ==========================================================
   // Bus cycles
   task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] wdat,
                           output logic [31:0] rdat);
      int w;
      @(posedge ref_clk);
      wb_req.cyc <= 1'b1;
      wb_req.stb <= 1'b1;
      wb_req.we  <= we;
      wb_req.adr <= adr;
      wb_req.sel <= 4'hf;
      wb_req.dat <= wdat;
      w = 0;
      do begin
         @(posedge ref_clk);
         w++;
      end while (wb_rsp.ack !== 1'b1 && w < 50);
      rdat = wb_rsp.dat;
      chk_bit(wb_rsp.ack, 1'b1);
      wb_req.cyc <= 1'b0;
      wb_req.stb <= 1'b0;
      wb_req.we  <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] d);
      logic [31:0] unused;
      wb_cycle(1'b1, adr, d, unused);
   endtask

   task automatic rd(input logic [7:0] adr, output logic [31:0] r);
      wb_cycle(1'b0, adr, 32'h0000_0000, r);
   endtask

   // Pins take two sync stages plus the output register
   task automatic settle();
      repeat (5) @(posedge ref_clk);
   endtask

   // ==========================================================
   // Scenarios
   // reset register values
   task automatic t_reset();
      logic [31:0] r;
      rd(`CSLA_REG_BLINK, r);
      chk_word(r, {16'h0000, `CSLA_BLINK_RST});
      rd(`CSLA_REG_IRQ_EN, r);
      chk_word(r, 32'h0000_0000);
      wr(8'h14, 32'hffff_ffff);
      rd(8'h14, r);
      chk_word(r, 32'h0000_0000);
   endtask

   task automatic t_lifecycle();
      csla_pkg::csla_lc_t st [6] = '{csla_pkg::CSLA_LC_PLUGGED, csla_pkg::CSLA_LC_INIT,
         csla_pkg::CSLA_LC_DOWNLOAD, csla_pkg::CSLA_LC_OUT_OF_SERVICE_STATE,
         csla_pkg::CSLA_LC_ACTIVE, csla_pkg::CSLA_LC_FAILED};
      // Blinking lamps are masked out here and timed separately
      logic [2:0] msk [6] = '{3'b111, 3'b101, 3'b011, 3'b111, 3'b111, 3'b111};
      logic [2:0] want [6] = '{3'b111, 3'b100, 3'b000, 3'b100, 3'b000, 3'b101};
      for (int i = 0; i < 6; i++) begin
         card_state <= st[i];
         settle();
         chk_lamp(card_lamp & msk[i], want[i]);
      end
   endtask

   task automatic t_alarms();
      card_state <= csla_pkg::CSLA_LC_ACTIVE;
      for (int i = 0; i < 8; i++) begin
         faults <= csla_pkg::csla_faults_t'(8'h01 << i);
         settle();
         chk_bit(major_alarm, 1'(i < 5));
         chk_bit(minor_alarm, 1'(i >= 5));
         chk_lamp(card_lamp, (i < 5) ? 3'b001 : 3'b010);
      end
      faults <= '0;
      high_rate_pll_lock <= 1'b0;
      settle();
      chk_bit(minor_alarm, 1'b1);
      high_rate_pll_lock <= 1'b1;
      low_rate_pll_lock <= 1'b0;
      settle();
      chk_bit(minor_alarm, 1'b1);
      low_rate_pll_lock <= 1'b1;
      faults <= csla_pkg::csla_faults_t'(8'h21);
      settle();
      chk_lamp(card_lamp, 3'b001);
      faults <= csla_pkg::csla_faults_t'(8'h24);
      settle();
      chk_bit(minor_alarm, 1'b0);
      card_state <= csla_pkg::CSLA_LC_FAILED;
      settle();
      chk_lamp(card_lamp, 3'b101);
      faults <= '0;
      card_state <= csla_pkg::CSLA_LC_ACTIVE;
      settle();
   endtask

   task automatic t_mezz();
      csla_pkg::csla_mz_t st [4] = '{csla_pkg::CSLA_MZ_MAJOR, csla_pkg::CSLA_MZ_MINOR,
         csla_pkg::CSLA_MZ_IDLE, csla_pkg::CSLA_MZ_ACTIVE};
      logic [2:0] want [4] = '{3'b001, 3'b010, 3'b100, 3'b000};
      mezz_state <= csla_pkg::CSLA_MZ_MAJOR;
      settle();
      chk_bit(mezz_presence_led, 1'b0);
      chk_lamp(mezz_lamp, 3'b000);
      mezz_installed <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         mezz_state <= st[i];
         settle();
         chk_bit(mezz_presence_led, 1'b1);
         chk_lamp(mezz_lamp, want[i]);
      end
   endtask

   task automatic t_irq();
      logic [31:0] r;
      wr(`CSLA_REG_IRQ_CLR, 32'h0000_000f);
      wr(`CSLA_REG_IRQ_EN, 32'h0000_0001);
      faults <= csla_pkg::csla_faults_t'(8'h01);
      settle();
      chk_bit(irq, 1'b1);
      rd(`CSLA_REG_STATUS, r);
      chk_word(r & 32'h0001_03ff, 32'h0001_0301);
      faults <= '0;
      settle();
      chk_bit(irq, 1'b1);
      wr(`CSLA_REG_IRQ_CLR, 32'h0000_0001);
      settle();
      chk_bit(irq, 1'b0);
      wr(`CSLA_REG_IRQ_EN, 32'h0000_0000);
      faults <= csla_pkg::csla_faults_t'(8'h01);
      settle();
      chk_bit(irq, 1'b0);
      rd(`CSLA_REG_IRQ_STAT, r);
      chk_word(r & 32'h0000_0001, 32'h0000_0001);
      faults <= '0;
      wr(`CSLA_REG_IRQ_CLR, 32'h0000_000f);
      wr(`CSLA_REG_IRQ_EN, 32'h0000_0004);
      mezz_installed <= 1'b0;
      settle();
      chk_bit(irq, 1'b1);
      wr(`CSLA_REG_IRQ_CLR, 32'h0000_000f);
      settle();
      chk_bit(irq, 1'b0);
   endtask

   task automatic t_blink();
      logic [15:0]        hp [2] = '{16'h0002, 16'h0000};
      int                 want [2] = '{2 * TICKS, TICKS};
      // Download blinks green, initialising blinks yellow
      csla_pkg::csla_lc_t lc [2] = '{csla_pkg::CSLA_LC_DOWNLOAD, csla_pkg::CSLA_LC_INIT};
      logic               prev;
      int                 n;
      logic [31:0]        r;
      for (int i = 0; i < 2; i++) begin
         card_state <= lc[i];
         wr(`CSLA_REG_BLINK, {16'h0000, hp[i]});
         rd(`CSLA_REG_BLINK, r);
         chk_word(r, {16'h0000, hp[i]});
         settle();
         // First edge aligns, the second interval is measured
         for (int k = 0; k < 2; k++) begin
            prev = card_lamp.green ^ card_lamp.yellow;
            n = 0;
            do begin
               @(posedge ref_clk);
               n++;
            end while ((card_lamp.green ^ card_lamp.yellow) === prev && n < 200);
         end
         chk_word(32'(n), 32'(want[i]));
         chk_bit(card_lamp.red, 1'b0);
      end
   endtask

   // ==========================================================
   // Sequence and watchdog
   initial begin
      repeat (4) @(posedge ref_clk);
      srst <= 1'b0;
      t_reset();
      t_lifecycle();
      t_alarms();
      t_mezz();
      t_irq();
      t_blink();
      wrap_up();
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      wrap_up();
   end

endmodule

`default_nettype wire
